// File: rtl/zaa_annunciator.sv
// eight-zone alarm annunciator: leds, sounder, zone and common outputs
// assumes synchronous inputs, loop alarm already classified per zone
module zaa_annunciator #(
  parameter int HOLD_CYC       = zaa_pkg::HOLD_CYC,
  parameter int DEBOUNCE_CYC   = zaa_pkg::DEBOUNCE_CYC,
  parameter int FLASH_HALF_CYC = zaa_pkg::FLASH_HALF_CYC,
  parameter int PULSE_HALF_CYC = zaa_pkg::PULSE_HALF_CYC
) (
  input  wire logic                      clock_in,        // 20 MHz clock
  input  wire logic                      reset_n_in,      // async reset, active low
  input  wire logic [zaa_pkg::ZONES-1:0] loop_alarm_in,   // loop out of secure band
  input  wire logic [zaa_pkg::ZONES-1:0] button_in,       // zone pushbutton, high pressed
  input  wire zaa_pkg::zaa_aux_t         aux_in,          // aux controls, active low
  input  wire logic                      delay_active_in, // entry or exit delay running
  input  wire logic                      cfg_load_in,     // host config strobe
  input  wire logic [zaa_pkg::ZONES-1:0] cfg_latch_in,    // per-zone latched output mode
  output zaa_pkg::zaa_leds_t             leds_out,        // zone status leds
  output logic [zaa_pkg::ZONES-1:0]      zone_out_out,    // individual zone outputs
  output logic [zaa_pkg::ZONES-1:0]      zone_oe_out,     // open collector enables
  output logic                           sounder_out,     // common output 1, sounder
  output logic                           relay_out        // common output 2, relay
);
  localparam int N = zaa_pkg::ZONES;
  localparam int W = zaa_pkg::CNT_W;

  logic rst_meta_q, rst_sync_q;
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  function automatic logic wrap(input logic [W-1:0] cnt, input int lim);
    return cnt >= W'(lim - 1);
  endfunction

  // shared flash and pulse timebases
  logic [W-1:0] flash_cnt_q, pulse_cnt_q;
  logic         flash_q, pulse_q;
  always_ff @(posedge clock_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      flash_cnt_q <= '0;
      pulse_cnt_q <= '0;
      flash_q     <= 1'b0;
      pulse_q     <= 1'b0;
    end else begin
      flash_cnt_q <= wrap(flash_cnt_q, FLASH_HALF_CYC) ? '0 : flash_cnt_q + 1'b1;
      pulse_cnt_q <= wrap(pulse_cnt_q, PULSE_HALF_CYC) ? '0 : pulse_cnt_q + 1'b1;
      if (wrap(flash_cnt_q, FLASH_HALF_CYC)) flash_q <= ~flash_q;
      if (wrap(pulse_cnt_q, PULSE_HALF_CYC)) pulse_q <= ~pulse_q;
    end
  end

  // aux inputs: level acts, acknowledge and reset as one-cycle edges
  logic ack_lvl_q, rst_lvl_q;
  always_ff @(posedge clock_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ack_lvl_q <= 1'b0;
      rst_lvl_q <= 1'b0;
    end else begin
      ack_lvl_q <= ~aux_in.acknowledge_n;
      rst_lvl_q <= ~aux_in.reset_n;
    end
  end
  logic aux_ack, aux_rst, shunt_locked, lamp_test;
  assign aux_ack      = ~aux_in.acknowledge_n & ~ack_lvl_q;
  assign aux_rst      = ~aux_in.reset_n & ~rst_lvl_q;
  assign shunt_locked = ~aux_in.shunt_lock_n;
  assign lamp_test    = ~aux_in.lamp_test_n;

  // per-zone button debounce and hold timing
  logic [N-1:0]        btn_q, short_q, long_q, long_done_q;
  logic [N-1:0][W-1:0] deb_cnt_q, hold_cnt_q;
  always_ff @(posedge clock_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      btn_q       <= '0;
      short_q     <= '0;
      long_q      <= '0;
      long_done_q <= '0;
      deb_cnt_q   <= '0;
      hold_cnt_q  <= '0;
    end else begin
      for (int z = 0; z < N; z++) begin
        short_q[z] <= 1'b0;
        long_q[z]  <= 1'b0;
        if (button_in[z] == btn_q[z]) begin
          deb_cnt_q[z] <= '0;
        end else if (wrap(deb_cnt_q[z], DEBOUNCE_CYC)) begin
          deb_cnt_q[z] <= '0;
          btn_q[z]     <= button_in[z];
          if (!button_in[z] && !long_done_q[z]) short_q[z] <= 1'b1;
        end else begin
          deb_cnt_q[z] <= deb_cnt_q[z] + 1'b1;
        end
        if (!btn_q[z]) begin
          hold_cnt_q[z]  <= '0;
          long_done_q[z] <= 1'b0;
        end else if (!long_done_q[z]) begin
          if (wrap(hold_cnt_q[z], HOLD_CYC)) begin
            long_q[z]      <= 1'b1;
            long_done_q[z] <= 1'b1;
          end else begin
            hold_cnt_q[z] <= hold_cnt_q[z] + 1'b1;
          end
        end
      end
    end
  end

  // zone alarm state
  logic [N-1:0] prev_loop_q, alarmed_q, acked_q, armed_q, latch_mode_q, latch_out_q;
  logic [N-1:0] new_alarm;
  assign new_alarm = loop_alarm_in & ~prev_loop_q & armed_q;

  always_ff @(posedge clock_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      prev_loop_q  <= '0;
      alarmed_q    <= '0;
      acked_q      <= '0;
      armed_q      <= zaa_pkg::ARMED_DEFAULT;
      latch_mode_q <= zaa_pkg::LATCH_DEFAULT;
      latch_out_q  <= '0;
    end else begin
      prev_loop_q <= loop_alarm_in;
      if (cfg_load_in) latch_mode_q <= cfg_latch_in;
      for (int z = 0; z < N; z++) begin
        if (long_q[z] && !shunt_locked) armed_q[z] <= ~armed_q[z];
        if (new_alarm[z]) begin
          alarmed_q[z]   <= 1'b1;
          acked_q[z]     <= 1'b0;
          latch_out_q[z] <= 1'b1;
        end else if (alarmed_q[z] && !acked_q[z] && (short_q[z] || aux_ack)) begin
          acked_q[z] <= 1'b1;
        end else if (alarmed_q[z] && acked_q[z] && !loop_alarm_in[z]
                     && (short_q[z] || aux_rst)) begin
          alarmed_q[z]   <= 1'b0;
          acked_q[z]     <= 1'b0;
          latch_out_q[z] <= 1'b0;
        end
      end
    end
  end

  // sounder silence, re-armed by any new alarm
  logic silenced_q;
  always_ff @(posedge clock_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      silenced_q <= 1'b0;
    end else if (|new_alarm) begin
      silenced_q <= 1'b0;
    end else if (aux_ack || |(short_q & alarmed_q & ~acked_q)) begin
      silenced_q <= 1'b1;
    end
  end

  logic [N-1:0] live_alarm;
  assign live_alarm = loop_alarm_in & armed_q;

  // a fresh alarm sounds in the same cycle as the relay, even if silenced
  logic sound_alarm;
  assign sound_alarm = |new_alarm || (|(alarmed_q & ~acked_q) && !silenced_q);

  always_ff @(posedge clock_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      leds_out     <= '0;
      zone_out_out <= '0;
      sounder_out  <= 1'b0;
      relay_out    <= 1'b0;
    end else begin
      if (lamp_test) begin
        leds_out <= '1;
      end else begin
        leds_out.green  <= ~loop_alarm_in;
        leds_out.red    <= alarmed_q & (acked_q | {N{flash_q}});
        leds_out.yellow <= ~armed_q;
      end
      for (int z = 0; z < N; z++)
        zone_out_out[z] <= latch_mode_q[z] ? (latch_out_q[z] | new_alarm[z]) : live_alarm[z];
      if (sound_alarm)
        sounder_out <= 1'b1;
      else
        sounder_out <= delay_active_in & pulse_q;
      relay_out <= |live_alarm;
    end
  end
  assign zone_oe_out = zone_out_out;

endmodule // zaa_annunciator

// File: rtl/zaa_pkg.sv
// zone alarm annunciator constants, carriers and defaults
// assumes 20 MHz system clock; loop state is classified upstream
package zaa_pkg;
  localparam int ZONES = 8;
  localparam int CLK_HZ = 20_000_000;
  localparam int HOLD_MS = 3000;
  localparam int DEBOUNCE_MS = 20;
  localparam int FLASH_HZ = 2;
  localparam int PULSE_HZ = 1;
  localparam int HOLD_CYC = CLK_HZ / 1000 * HOLD_MS + 1;
  localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int FLASH_HALF_CYC = CLK_HZ / (2 * FLASH_HZ);
  localparam int PULSE_HALF_CYC = CLK_HZ / (2 * PULSE_HZ);
  localparam int CNT_W = 27;
  localparam logic [ZONES-1:0] LATCH_DEFAULT = 8'hff;
  localparam logic [ZONES-1:0] ARMED_DEFAULT = 8'hff;

  typedef struct packed {
    logic acknowledge_n;
    logic reset_n;
    logic lamp_test_n;
    logic shunt_lock_n;
  } zaa_aux_t;

  typedef struct packed {
    logic [ZONES-1:0] yellow;
    logic [ZONES-1:0] green;
    logic [ZONES-1:0] red;
  } zaa_leds_t;
endpackage : zaa_pkg

// File: bench/zaa_annunciator_props.sv
// checker on the annunciator top ports
// assumes the bench runs the short timing parameters
module zaa_annunciator_props (
  input wire logic               clock_in,
  input wire logic               reset_n_in,
  input wire logic [7:0]         loop_alarm_in,
  input wire zaa_pkg::zaa_aux_t  aux_in,
  input wire logic               delay_active_in,
  input wire zaa_pkg::zaa_leds_t leds_out,
  input wire logic [7:0]         zone_out_out,
  input wire logic [7:0]         zone_oe_out,
  input wire logic               sounder_out,
  input wire logic               relay_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] up_q;
  always_ff @(posedge clock_in or negedge reset_n_in)
    if (!reset_n_in) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  a_oe_mirror: assert property (zone_oe_out == zone_out_out)
    else $error("oe differs");
  a_green_loop: assert property (up_q == 3'h7 && $past(aux_in.lamp_test_n)
    |-> leds_out.green == ~$past(loop_alarm_in)) else $error("green wrong");
  a_lamp_all: assert property (up_q == 3'h7 && !$past(aux_in.lamp_test_n)
    |-> &leds_out) else $error("lamp test dark");
  a_relay_off: assert property (loop_alarm_in == 8'h0 |=> !relay_out)
    else $error("relay held");
  a_relay_zone: assert property (relay_out |-> zone_out_out != 8'h0)
    else $error("relay without zone");
  a_alarm_sound: assert property ($rose(relay_out) |-> sounder_out)
    else $error("sounder quiet");
  a_alarm_dark: assert property ($rose(zone_out_out[0]) && $past(aux_in.lamp_test_n)
    |-> !leds_out.green[0]) else $error("green lit in alarm");
  a_zone_hold: assert property (zone_out_out[0] && loop_alarm_in[0] |=> zone_out_out[0])
    else $error("zone output dropped");
  a_ack_silence: assert property ($fell(aux_in.acknowledge_n) && !delay_active_in
    && $stable(loop_alarm_in) ##1 $stable(loop_alarm_in) && !delay_active_in
    |=> !sounder_out) else $error("sounder not silenced");
endmodule // zaa_annunciator_props
bind zaa_annunciator zaa_annunciator_props u_props (.clock_in(clock_in),
  .reset_n_in(reset_n_in), .loop_alarm_in(loop_alarm_in), .aux_in(aux_in),
  .delay_active_in(delay_active_in), .leds_out(leds_out), .zone_out_out(zone_out_out),
  .zone_oe_out(zone_oe_out), .sounder_out(sounder_out), .relay_out(relay_out));

// File: bench/zaa_field_model.sv
// field side: loop contacts and bouncing zone pushbuttons
// assumes the bench holds press_in for the whole press
module zaa_field_model (
  input  wire logic       clock_in,           // system clock
  input  wire logic [7:0] loop_set_in,        // loops to open
  input  wire logic [7:0] press_in,           // buttons held
  output logic      [7:0] loop_alarm_out = 8'h0, // loop state
  output logic      [7:0] button_out = 8'h0      // contact level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] age_q = 2'h0;
  always @(posedge clock_in) begin
    loop_alarm_out <= loop_set_in;
    age_q <= press_in == 8'h0 ? 2'h0 : (age_q == 2'h3 ? 2'h3 : age_q + 2'h1);
    button_out <= age_q == 2'h1 ? 8'h0 : press_in;
  end
endmodule // zaa_field_model

// File: bench/zaa_annunciator_tb.sv
// self-checking bench for the zone alarm annunciator
// assumes short timing parameters; zone 0 is the target
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module zaa_annunciator_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEB = 4;
  logic clk = 0, rst_n = 0, dly = 0, cfg_ld = 0, snd, rly;
  logic [7:0] loops = 0, press = 0, latch = 8'hff, loop_w, btn_w, zo, zoe;
  zaa_pkg::zaa_aux_t aux = 4'hf;
  zaa_pkg::zaa_leds_t leds;
  int num_errors = 0, checks_done = 0;
  logic [7:0] exp_q[$];
  event look;
  zaa_field_model field (.clock_in(clk), .loop_set_in(loops), .press_in(press),
    .loop_alarm_out(loop_w), .button_out(btn_w));
  zaa_annunciator #(.HOLD_CYC(50), .DEBOUNCE_CYC(DEB), .FLASH_HALF_CYC(8),
    .PULSE_HALF_CYC(16)) dut (.clock_in(clk), .reset_n_in(rst_n), .loop_alarm_in(loop_w),
    .button_in(btn_w), .aux_in(aux), .delay_active_in(dly), .cfg_load_in(cfg_ld),
    .cfg_latch_in(latch), .leds_out(leds), .zone_out_out(zo), .zone_oe_out(zoe),
    .sounder_out(snd), .relay_out(rly));
  task automatic wait_cyc(int n);
    repeat (n) @(posedge clk);
  endtask
  // vector: green, yellow, zone, relay, red seen on/off, sounder seen on/off
  task automatic expect_v(logic [7:0] v);
    wait_cyc(6);
    exp_q.push_back(v);
    ->look;
    wait_cyc(40);
  endtask
  task automatic push(int len);
    press <= 8'h1;
    wait_cyc(len);
    press <= 8'h0;
    wait_cyc(DEB + 4);
  endtask
  task automatic aux_pulse(logic [3:0] m);
    aux <= ~m;
    wait_cyc(2);
    aux <= 4'hf;
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial forever #25 clk = ~clk;
  initial forever begin : mon
    logic [1:0] r, s;
    logic [7:0] e;
    @(look);
    r = 2'h0;
    s = 2'h0;
    repeat (36) begin
      @(negedge clk);
      r |= {leds.red[0], !leds.red[0]};
      s |= {snd, !snd};
    end
    e = exp_q.pop_front();
    `CHK("status", e, {leds.green[0], leds.yellow[0], zo[0], rly, r, s})
  end
  initial begin
    wait_cyc(20000);
    num_errors++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h6a04));
    wait_cyc(5);
    rst_n <= 1'b1;
    wait_cyc(4);
    expect_v(8'b1000_0101);
    for (int it = 0; it < 2; it++) begin
      if (it == 1) begin
        latch <= {7'($urandom), 1'b0};
        cfg_ld <= 1'b1;
        wait_cyc(1);
        cfg_ld <= 1'b0;
      end
      loops <= 8'h1;
      expect_v(8'b0011_1110);
      if (it == 0) push(DEB + 2 + $urandom % 4);
      else aux_pulse(4'h8);
      expect_v(8'b0011_1001);
      loops <= 8'h0;
      expect_v({2'b10, it == 0, 5'b0_1001});
      if (it == 0) push(DEB + 2 + $urandom % 4);
      else aux_pulse(4'h4);
      expect_v(8'b1000_0101);
    end
    push(70);
    expect_v(8'b1100_0101);
    loops <= 8'h1;
    expect_v(8'b0100_0101);
    loops <= 8'h0;
    push(70);
    expect_v(8'b1000_0101);
    dly <= 1'b1;
    expect_v(8'b1000_0111);
    dly <= 1'b0;
    aux_pulse(4'h2);
    expect_v(8'b1000_0101);
    aux <= 4'he;
    push(70);
    expect_v(8'b1000_0101);
    aux <= 4'hf;
    wrap_up();
  end
endmodule // zaa_annunciator_tb
